//--- src/sys_clock_power_ctrl.sv
// system clock source selection and operating mode sequencer with apb registers.
// assumes oscillator ticks are one-cycle pulses synchronous to i_clk_sys, and
// that halt and wake requests come from the cpu and wake logic as pulses.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

module sys_clock_power_ctrl
	import clk_mode_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        i_fast_tick,
	input  wire logic        i_slow_tick,
	input  wire logic        i_fast_src_xtal,
	input  wire logic        i_wdt_en,
	input  wire logic        i_halt,
	input  wire logic        i_wake,
	output logic             o_fast_osc_en,
	output logic             o_slow_osc_en,
	output logic             o_sys_clk_en,
	output logic             o_cpu_clk_en,
	output logic             o_sub_clk_en,
	output logic             o_tbc_clk_en,
	output logic [2:0]       o_mode
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// selection code is {fast_sel, div_sel}; true when it needs the fast source
	function automatic logic sel_is_fast(input logic [3:0] sel);
		sel_is_fast = sel[3] | (sel[2:0] >= DIV_FIRST_FAST);
	endfunction

	// last divider count for a divided fast selection, fast/64 .. fast/2
	function automatic logic [5:0] div_last(input logic [2:0] code);
		case (code)
			3'h2:    div_last = 6'h3f;
			3'h3:    div_last = 6'h1f;
			3'h4:    div_last = 6'h0f;
			3'h5:    div_last = 6'h07;
			3'h6:    div_last = 6'h03;
			default: div_last = 6'h01;
		endcase
	endfunction

	ctl_s r_ff;
	ctl_s nxt_r;

	logic [3:0]  req_sel;
	logic        req_fast;
	logic        act_fast;
	logic        req_ready;
	logic        sys_tick;
	logic        div_tick;
	logic        apb_setup;
	logic        apb_write;
	logic        addr_ok;
	logic [10:0] fast_target;

	////////////////////////////////////////////////////////////////////////////
	// combinational decode of selection and ticks

	always_comb begin
		req_sel     = {r_ff.fast_sel, r_ff.div_sel};
		req_fast    = sel_is_fast(req_sel);
		act_fast    = sel_is_fast(r_ff.active_sel);
		req_ready   = req_fast ? r_ff.fast_rdy : r_ff.slow_rdy;
		fast_target = i_fast_src_xtal ? XTAL_SETTLE : FRC_SETTLE; // R14
		div_tick    = i_fast_tick & r_ff.fast_rdy
			& (r_ff.div_cnt == div_last(r_ff.active_sel[2:0]));
		// system tick from the active source only; substitute overrides it
		if (r_ff.use_sub) begin
			sys_tick = i_slow_tick & r_ff.slow_rdy; // R12
		end else if (!act_fast) begin
			sys_tick = i_slow_tick & r_ff.slow_rdy; // R4
		end else if (r_ff.active_sel[3]) begin
			sys_tick = i_fast_tick & r_ff.fast_rdy; // R10
		end else begin
			sys_tick = div_tick; // R3
		end
		apb_setup = psel & ~penable;
		apb_write = psel & penable & pwrite;
		addr_ok   = (paddr == OFS_CLOCK_MODE) | (paddr == OFS_HALT_CTRL)
			| (paddr == OFS_STATUS);
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_r = r_ff;

		// register writes; ready flags are read-only and ignore writes
		if (apb_write && pstrb[0] && paddr == OFS_CLOCK_MODE) begin
			nxt_r.div_sel      = pwdata[POS_DIV_SEL +: 3];
			nxt_r.fast_wake_en = pwdata[POS_FAST_WAKE];
			nxt_r.idle_on_halt = pwdata[POS_IDLE_HALT];
			nxt_r.fast_sel     = pwdata[POS_FAST_SEL];
		end
		if (apb_write && pstrb[0] && paddr == OFS_HALT_CTRL) begin
			nxt_r.keep_clock = pwdata[0];
		end

		// read data captured in the setup phase so it stands in the access phase
		if (apb_setup) begin
			nxt_r.pslverr = ~addr_ok;
			case (paddr)
				OFS_CLOCK_MODE: nxt_r.prdata = {24'h00_0000, r_ff.div_sel, r_ff.fast_wake_en,
					r_ff.slow_rdy, r_ff.fast_rdy, r_ff.idle_on_halt, r_ff.fast_sel};
				OFS_HALT_CTRL:  nxt_r.prdata = {31'h0000_0000, r_ff.keep_clock};
				OFS_STATUS:     nxt_r.prdata = {24'h00_0000, r_ff.active_sel, r_ff.use_sub,
					r_ff.state};
				default:        nxt_r.prdata = 32'h0000_0000;
			endcase
		end

		// oscillator enables per operating mode
		case (r_ff.state)
			ST_RUN, ST_WAKE: begin
				// fast held on while still active, so a switch away is clean
				nxt_r.fast_osc_en = req_fast | act_fast; // R2 R10 R19
				nxt_r.slow_osc_en = 1'b1;
			end
			ST_CLOCK_RUNNING_IDLE: begin
				nxt_r.fast_osc_en = act_fast; // R8
				nxt_r.slow_osc_en = 1'b1;
			end
			ST_CLOCK_STOPPED_IDLE: begin
				nxt_r.fast_osc_en = 1'b0; // R7
				nxt_r.slow_osc_en = 1'b1; // R7
			end
			ST_WATCHDOG_SLEEP_MODE: begin
				nxt_r.fast_osc_en = 1'b0; // R6
				nxt_r.slow_osc_en = 1'b1; // R6
			end
			default: begin
				nxt_r.fast_osc_en = 1'b0; // R5
				nxt_r.slow_osc_en = 1'b0; // R5
			end
		endcase

		// fast ready: counts fast ticks from enable, cleared whenever stopped
		if (!r_ff.fast_osc_en) begin
			nxt_r.fast_rdy = 1'b0; // R14
			nxt_r.fast_cnt = 11'h000;
		end else if (!r_ff.fast_rdy && i_fast_tick) begin
			if (r_ff.fast_cnt == fast_target - 11'h001) begin
				nxt_r.fast_rdy = 1'b1; // R14 R16 R17
			end else begin
				nxt_r.fast_cnt = r_ff.fast_cnt + 11'h001;
			end
		end

		// slow ready: same scheme on the slow rc
		if (!r_ff.slow_osc_en) begin
			nxt_r.slow_rdy = 1'b0; // R13
			nxt_r.slow_cnt = 2'h0;
		end else if (!r_ff.slow_rdy && i_slow_tick) begin
			if (r_ff.slow_cnt == SRC_SETTLE - 2'h1) begin
				nxt_r.slow_rdy = 1'b1; // R13
			end else begin
				nxt_r.slow_cnt = r_ff.slow_cnt + 2'h1;
			end
		end

		// divider runs on fast ticks; restarts on every division boundary
		if (i_fast_tick && r_ff.fast_rdy) begin
			nxt_r.div_cnt = div_tick ? 6'h00 : r_ff.div_cnt + 6'h01; // R3 R9
		end

		// source switch waits for the new source; only done between ticks
		if (req_sel != r_ff.active_sel && req_ready && !sys_tick && !r_ff.use_sub
			&& (r_ff.state == ST_RUN || r_ff.state == ST_WAKE)) begin
			nxt_r.active_sel = req_sel; // R20
			nxt_r.div_cnt    = 6'h00; // R20
		end

		// substitute clock ends once the crystal is ready
		if (r_ff.use_sub && r_ff.fast_rdy) begin
			nxt_r.use_sub = 1'b0; // R16
		end

		// mode sequencing
		case (r_ff.state)
			ST_RUN: begin
				if (i_halt) begin
					if (r_ff.idle_on_halt) begin
						nxt_r.state = r_ff.keep_clock ? ST_CLOCK_RUNNING_IDLE : ST_CLOCK_STOPPED_IDLE; // R11 R7 R8
					end else begin
						nxt_r.state = i_wdt_en ? ST_WATCHDOG_SLEEP_MODE : ST_DEEP_SLEEP_MODE; // R11 R5 R6
					end
				end
			end
			ST_CLOCK_RUNNING_IDLE: begin
				// clock kept running, so the next system tick resumes the cpu
				if (i_wake) begin
					nxt_r.state = ST_WAKE; // R18
					nxt_r.fast_wake_go = 1'b0;
				end
			end
			ST_CLOCK_STOPPED_IDLE, ST_WATCHDOG_SLEEP_MODE: begin
				if (i_wake) begin
					nxt_r.state = ST_WAKE;
					nxt_r.fast_wake_go = r_ff.fast_wake_en & i_fast_src_xtal & act_fast; // R15 R12 R17
				end
			end
			ST_DEEP_SLEEP_MODE: begin
				if (i_wake) begin
					nxt_r.state = ST_WAKE;
					nxt_r.fast_wake_go = 1'b0; // R15
				end
			end
			ST_WAKE: begin
				if (r_ff.fast_wake_go) begin
					// substitute clock already running; one slow tick to resume
					if (i_slow_tick && r_ff.slow_rdy) begin
						nxt_r.state        = ST_RUN; // R16
						nxt_r.use_sub      = ~r_ff.fast_rdy; // R1 R16
						nxt_r.fast_wake_go = 1'b0;
					end
				end else if (sys_tick) begin
					nxt_r.state = ST_RUN; // R17 R18
				end
			end
			default: begin
				nxt_r.state = ST_RUN;
			end
		endcase

		// clock enables out: sub and time base from the slow rc only
		nxt_r.sys_clk_en = sys_tick & (r_ff.state == ST_RUN || r_ff.state == ST_CLOCK_RUNNING_IDLE); // R8
		nxt_r.cpu_clk_en = sys_tick & (r_ff.state == ST_RUN); // R3 R4
		nxt_r.sub_clk_en = i_slow_tick & r_ff.slow_rdy & r_ff.slow_osc_en; // R1
		nxt_r.tbc_clk_en = i_slow_tick & r_ff.slow_rdy & r_ff.slow_osc_en
			& (r_ff.state != ST_WATCHDOG_SLEEP_MODE) & (r_ff.state != ST_DEEP_SLEEP_MODE); // R1 R6
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	// reset selects undivided fast; cpu waits until it has settled
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			r_ff.div_sel      <= RST_CLOCK_MODE[POS_DIV_SEL +: 3];
			r_ff.fast_wake_en <= RST_CLOCK_MODE[POS_FAST_WAKE];
			r_ff.idle_on_halt <= RST_CLOCK_MODE[POS_IDLE_HALT];
			r_ff.fast_sel     <= RST_CLOCK_MODE[POS_FAST_SEL];
			r_ff.keep_clock   <= RST_KEEP_CLOCK[0];
			r_ff.state        <= ST_RUN;
			r_ff.active_sel   <= {RST_CLOCK_MODE[POS_FAST_SEL], RST_CLOCK_MODE[POS_DIV_SEL +: 3]};
			r_ff.use_sub      <= 1'b0;
			r_ff.fast_rdy     <= 1'b0;
			r_ff.slow_rdy     <= 1'b0;
			r_ff.fast_cnt     <= 11'h000;
			r_ff.slow_cnt     <= 2'h0;
			r_ff.div_cnt      <= 6'h00;
			r_ff.fast_wake_go <= 1'b0;
			r_ff.prdata       <= 32'h0000_0000;
			r_ff.pslverr      <= 1'b0;
			r_ff.sys_clk_en   <= 1'b0;
			r_ff.cpu_clk_en   <= 1'b0;
			r_ff.sub_clk_en   <= 1'b0;
			r_ff.tbc_clk_en   <= 1'b0;
			r_ff.fast_osc_en  <= 1'b1;
			r_ff.slow_osc_en  <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// zero wait states: the access phase always completes at once
	assign pready        = 1'b1;
	assign prdata        = r_ff.prdata;
	assign pslverr       = r_ff.pslverr & psel & penable;
	assign o_fast_osc_en = r_ff.fast_osc_en;
	assign o_slow_osc_en = r_ff.slow_osc_en;
	assign o_sys_clk_en  = r_ff.sys_clk_en;
	assign o_cpu_clk_en  = r_ff.cpu_clk_en;
	assign o_sub_clk_en  = r_ff.sub_clk_en;
	assign o_tbc_clk_en  = r_ff.tbc_clk_en;
	assign o_mode        = r_ff.state;

endmodule

`default_nettype wire

//--- common/clk_mode_pkg.sv
// package for the system clock and power mode controller: register map,
// field positions, reset values, oscillator settle counts and state types.
// assumes a single 25 MHz register clock; oscillators arrive as tick pulses.
//
// Functional notes
// R1: substitute and time base clocks come from slow RC; substitute speeds wake-up.
// R2: moving system clock to slow stops fast oscillator and all fast-derived clocks.
// R3: normal mode runs CPU from fast source divided by 1 to 64.
// R4: slow mode runs CPU from slow RC with fast clock off.
// R5: halt, idle bit low, watchdog off: deepest sleep, everything stops.
// R6: halt, idle bit low, watchdog on: CPU and system clock stop, slow RC runs.
// R7: halt, idle bit high, keep-clock low: system oscillator stops, slow clocks stay.
// R8: halt, idle and keep-clock high: CPU stops, system oscillator keeps running.
// R9: divider select 000/001 slow, 010..111 fast/64 down to fast/2.
// R10: fast-select high gives undivided fast; slow choice switches fast clock off.
// R11: idle bit chooses idle or sleep on halt.
// R12: fast wake with crystal source runs on substitute clock after wake-up.
// R13: slow-ready flag low in deepest sleep, high 1-2 slow ticks after start.
// R14: fast-ready flag low when stopped; sets after 1024 crystal or 16 RC ticks.
// R15: fast wake only from watchdog sleep or clock-stopped idle.
// R16: crystal fast wake: run on substitute, switch to crystal when fast ready.
// R17: RC sources wake after their settle ticks; fast wake bit ignored.
// R18: wake from clock-running idle takes one system clock tick.
// R19: slow mode reached by clearing fast-select with divider select 000/001.
// R20: source switch held until new source ready, switched on tick boundaries.
package clk_mode_pkg;

	// register byte offsets on the apb bus
	localparam logic [11:0] OFS_CLOCK_MODE  = 12'h000;
	localparam logic [11:0] OFS_HALT_CTRL   = 12'h004;
	localparam logic [11:0] OFS_STATUS      = 12'h008;

	// clock mode register fields
	localparam int          POS_DIV_SEL     = 5;
	localparam int          POS_FAST_WAKE   = 4;
	localparam int          POS_SLOW_RDY    = 3;
	localparam int          POS_FAST_RDY    = 2;
	localparam int          POS_IDLE_HALT   = 1;
	localparam int          POS_FAST_SEL    = 0;
	localparam logic [7:0]  RST_CLOCK_MODE  = 8'h03;
	localparam logic [0:0]  RST_KEEP_CLOCK  = 1'h0;

	// divider select codes below this pick the slow clock
	localparam logic [2:0]  DIV_FIRST_FAST  = 3'h2;

	// oscillator settle counts, in ticks of that oscillator
	localparam logic [10:0] XTAL_SETTLE     = 11'h400;
	localparam logic [10:0] FRC_SETTLE      = 11'h010;
	localparam logic [1:0]  SRC_SETTLE      = 2'h2;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b000,
		ST_CLOCK_STOPPED_IDLE  = 3'b001,
		ST_CLOCK_RUNNING_IDLE  = 3'b010,
		ST_DEEP_SLEEP_MODE = 3'b011,
		ST_WATCHDOG_SLEEP_MODE = 3'b100,
		ST_WAKE   = 3'b101
	} pwr_state_e;

	typedef struct packed {
		logic [2:0]  div_sel;
		logic        fast_wake_en;
		logic        idle_on_halt;
		logic        fast_sel;
		logic        keep_clock;
		pwr_state_e  state;
		logic [3:0]  active_sel;
		logic        use_sub;
		logic        fast_rdy;
		logic        slow_rdy;
		logic [10:0] fast_cnt;
		logic [1:0]  slow_cnt;
		logic [5:0]  div_cnt;
		logic        fast_wake_go;
		logic [31:0] prdata;
		logic        pslverr;
		logic        sys_clk_en;
		logic        cpu_clk_en;
		logic        sub_clk_en;
		logic        tbc_clk_en;
		logic        fast_osc_en;
		logic        slow_osc_en;
	} ctl_s;

endpackage

//--- sim/sys_clock_power_ctrl_monitor.sv
// port checker for the clock and power mode controller.
// assumes it is bound into sys_clock_power_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module sys_clock_power_ctrl_monitor
	import clk_mode_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        i_slow_tick,
	input wire logic        i_wdt_en,
	input wire logic        i_halt,
	input wire logic        i_wake,
	input wire logic        o_fast_osc_en,
	input wire logic        o_slow_osc_en,
	input wire logic        o_sys_clk_en,
	input wire logic        o_cpu_clk_en,
	input wire logic        o_sub_clk_en,
	input wire logic        o_tbc_clk_en,
	input wire logic [2:0]  o_mode
);
	logic       idle_ff;
	logic       keep_ff;
	logic [2:0] halt_to;
	////////////////////////////////////////////////////////////////////////
	// shadow of the two halt bits, snooped from completed apb writes
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			idle_ff <= RST_CLOCK_MODE[POS_IDLE_HALT];
			keep_ff <= RST_KEEP_CLOCK[0];
		end else if (psel && penable && pwrite && pstrb[0]) begin
			if (paddr == OFS_CLOCK_MODE)
				idle_ff <= pwdata[POS_IDLE_HALT];
			if (paddr == OFS_HALT_CTRL)
				keep_ff <= pwdata[0];
		end
	end
	// mode a halt should land in, given the shadowed bits and watchdog
	always_comb begin
		if (idle_ff)
			halt_to = keep_ff ? ST_CLOCK_RUNNING_IDLE : ST_CLOCK_STOPPED_IDLE;
		else
			halt_to = i_wdt_en ? ST_WATCHDOG_SLEEP_MODE : ST_DEEP_SLEEP_MODE;
	end
	////////////////////////////////////////////////////////////////////////
	// enables are registered, so levels are judged after three cycles in a mode
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	chk_halt_target: assert property (i_halt && o_mode == ST_RUN |=> o_mode == $past(halt_to))
		else $error("halt landed in the wrong mode");
	chk_halt_ignored: assert property (i_halt && !i_wake && o_mode inside {[1:4]} |=> $stable(o_mode))
		else $error("halt changed a halted mode");
	chk_wake_start: assert property (i_wake && o_mode inside {[1:4]} |=> o_mode inside {ST_WAKE, ST_RUN})
		else $error("wake did not leave the halted mode");
	chk_deep_off: assert property ((o_mode == ST_DEEP_SLEEP_MODE)[*3] |-> !o_slow_osc_en && !o_fast_osc_en && !o_tbc_clk_en && !o_sub_clk_en)
		else $error("deep sleep left a clock running");
	chk_wdt_sleep: assert property ((o_mode == ST_WATCHDOG_SLEEP_MODE)[*3] |-> o_slow_osc_en && !o_tbc_clk_en && !o_sys_clk_en)
		else $error("watchdog sleep clocks wrong");
	chk_clock_stopped_idle_stop: assert property ((o_mode == ST_CLOCK_STOPPED_IDLE)[*3] |-> o_slow_osc_en && !o_sys_clk_en && !o_fast_osc_en)
		else $error("stopped idle clocks wrong");
	chk_clock_running_idle_keep: assert property ((o_mode == ST_CLOCK_RUNNING_IDLE)[*3] |-> o_slow_osc_en && !o_cpu_clk_en)
		else $error("running idle clocks wrong");
	chk_cpu_halted: assert property (o_mode != ST_RUN && $past(o_mode) != ST_RUN |-> !o_cpu_clk_en)
		else $error("cpu ticked while halted");
	chk_sub_source: assert property (o_sub_clk_en || o_tbc_clk_en |-> $past(i_slow_tick))
		else $error("substitute tick without slow tick");
endmodule
bind sys_clock_power_ctrl sys_clock_power_ctrl_monitor u_mon (.i_clk_sys, .i_srst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .i_slow_tick, .i_wdt_en, .i_halt, .i_wake, .o_fast_osc_en,
	.o_slow_osc_en, .o_sys_clk_en, .o_cpu_clk_en, .o_sub_clk_en, .o_tbc_clk_en, .o_mode);
`default_nettype wire

//--- sim/tb_system_clock_power_mode_control.sv
// self-checking bench for the clock and power mode controller.
// assumes one-cycle apb answers; oscillator ticks are modelled here, gated by enables.
`timescale 1ns/100ps
`default_nettype none
module tb_system_clock_power_mode_control;
	import clk_mode_pkg::*;
	logic i_clk_sys = 0, i_srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, i_fast_tick = 0, i_slow_tick = 0, i_fast_src_xtal = 0;
	logic i_wdt_en = 0, i_halt = 0, i_wake = 0, fast_run = 0, slow_run = 0;
	logic o_fast_osc_en, o_slow_osc_en, o_sys_clk_en, o_cpu_clk_en, o_sub_clk_en, o_tbc_clk_en;
	logic [2:0] o_mode, sc = 0;
	logic [2:0] em [4] = '{ST_DEEP_SLEEP_MODE, ST_WATCHDOG_SLEEP_MODE, ST_CLOCK_STOPPED_IDLE, ST_CLOCK_RUNNING_IDLE};
	int nf = 0, ns = 0, cyc = 0, n_mismatch = 0, check_count = 0;
	sys_clock_power_ctrl dut (.i_clk_sys, .i_srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .pready, .prdata, .pslverr, .i_fast_tick, .i_slow_tick, .i_fast_src_xtal,
		.i_wdt_en, .i_halt, .i_wake, .o_fast_osc_en, .o_slow_osc_en, .o_sys_clk_en,
		.o_cpu_clk_en, .o_sub_clk_en, .o_tbc_clk_en, .o_mode);
	always #20 i_clk_sys = ~i_clk_sys;
	////////////////////////////////////////////////////////////////////////
	// oscillators only tick while enabled: fast every 2 cycles, slow every 8
	always @(posedge i_clk_sys) begin
		sc <= sc + 3'h1;
		i_fast_tick <= o_fast_osc_en & fast_run & ~i_fast_tick;
		i_slow_tick <= o_slow_osc_en & slow_run & (sc == 3'h0);
		nf <= nf + int'(i_fast_tick);
		ns <= ns + int'(i_slow_tick);
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk_sys);
		penable <= 1;
		// no local limit: only the bench timeout may end this wait
		do begin
			@(posedge i_clk_sys);
		end while (pready !== 1'b1);
		rd = {pslverr, prdata[30:0]};
		psel <= 0;
		penable <= 0;
		// one idle edge, so a following call never reassigns psel in the same step
		@(posedge i_clk_sys);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// upper bit of a read carries pslverr, register data never reaches it
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		apb(0, a, 0, d);
		chk(d, exp);
	endtask
	task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] d;
		int n;
		n = 0;
		do begin
			apb(0, a, 0, d);
			n++;
		end while ((d & m) !== v && n < 1500);
		chk(d & m, v);
	endtask
	// first pass aligns to a system tick, second measures the spacing
	task automatic gap(input int exp);
		int g;
		repeat (2) begin
			g = 0;
			do begin
				@(posedge i_clk_sys);
				g++;
			end while (o_sys_clk_en !== 1'b1 && g < 300);
		end
		chk(32'(g), 32'(exp));
	endtask
	// one-cycle halt (wake low) or wake (wake high) request
	task automatic pulse(input logic wake);
		if (wake) begin
			i_wake <= 1;
		end else begin
			i_halt <= 1;
		end
		@(posedge i_clk_sys);
		i_wake <= 0;
		i_halt <= 0;
		@(posedge i_clk_sys);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		repeat (3) @(posedge i_clk_sys);
		i_srst <= 0;
		fast_run = 1;
		rdc(OFS_CLOCK_MODE, 32'h0000_0003);
		rdc(OFS_HALT_CTRL, 32'h0000_0000);
		rdc(OFS_STATUS, 32'h0000_0080);
		rdc(12'h00C, 32'h8000_0000);
		wait (nf == 15);
		fast_run = 0;
		rdc(OFS_CLOCK_MODE, 32'h0000_0003);
		fast_run = 1;
		wait (nf == 16);
		rdc(OFS_CLOCK_MODE, 32'h0000_0007);
		slow_run = 1;
		wait (ns == 1);
		slow_run = 0;
		rdc(OFS_CLOCK_MODE, 32'h0000_0007);
		slow_run = 1;
		wait (ns == 2);
		apb(1, OFS_CLOCK_MODE, 32'h0000_0003, d);
		rdc(OFS_CLOCK_MODE, 32'h0000_000F);
		gap(2);
		apb(1, OFS_CLOCK_MODE, 32'h0000_0002, d);
		poll(OFS_STATUS, 32'h0000_00F0, 32'h0000_0000);
		gap(8);
		chk(32'(o_fast_osc_en), 32'h0000_0000);
		apb(1, OFS_CLOCK_MODE, 32'h0000_0022, d);
		gap(8);
		for (int k = 2; k < 8; k++) begin
			apb(1, OFS_CLOCK_MODE, {24'h0, k[2:0], 5'h02}, d);
			poll(OFS_STATUS, 32'h0000_00F0, {24'h0, 1'b0, k[2:0], 4'h0});
			gap(2 * (256 >> k));
		end
		// second pass repeats every halt mode with crystal and fast wake on
		for (int p = 0; p < 2; p++) begin
			i_fast_src_xtal <= p[0];
			for (int c = 0; c < 4; c++) begin
				i_wdt_en <= c[0];
				apb(1, OFS_CLOCK_MODE, {24'h0, 3'h0, p[0], 2'h0, c[1], 1'b1}, d);
				apb(1, OFS_HALT_CTRL, {31'h0, c[0]}, d);
				pulse(1'b0);
				chk(32'(o_mode), 32'(em[c]));
				pulse(1'b0);
				chk(32'(o_mode), 32'(em[c]));
				rdc(OFS_CLOCK_MODE, {24'h0, 3'h0, p[0], c != 0, c == 3, c[1], 1'b1});
				chk(32'({o_fast_osc_en, o_slow_osc_en}), 32'({c == 3, c != 0}));
				pulse(1'b1);
				poll(OFS_STATUS, 32'h0000_0007, 32'h0000_0000);
				rdc(OFS_STATUS, {24'h0, 4'h8, 1'(p == 1 && (c == 1 || c == 2)), 3'h0});
				poll(OFS_CLOCK_MODE, 32'h0000_0004, 32'h0000_0004);
				rdc(OFS_STATUS, 32'h0000_0080);
			end
		end
		print_verdict();
	end
endmodule
`default_nettype wire
